// File: shared/mfbc_pkg.sv
/*
 * package for the memory field bounds checker: address widths, field
 * alignment, a carrier struct for the four field registers and the operand target code.
 * assumes a word-addressed 24-bit central memory and 64-word field alignment.
 */
package mfbc_pkg;

    // ------------------------------------------------------------
    // widths and alignment
    // ------------------------------------------------------------
    localparam int ADDR_W  = 24;   // absolute memory address
    localparam int FIELD_W = 18;   // stored base or limit bits
    localparam int ALIGN_W = 6;    // implied zero low bits
    localparam int PC_W    = 22;   // program counter high-order bits
    localparam int DATA_W  = 64;   // memory word

    localparam logic [ALIGN_W-1:0] ALIGN_ZERO = 6'h00;

    typedef logic [ADDR_W-1:0]  mfbc_addr_t;
    typedef logic [FIELD_W-1:0] mfbc_field_t;

    // ------------------------------------------------------------
    // carrier structs
    // ------------------------------------------------------------
    // field bounds of the active context block
    typedef struct packed {
        mfbc_field_t instruction_field_base;
        mfbc_field_t instruction_field_limit;
        mfbc_field_t data_field_base;
        mfbc_field_t data_field_limit;
    } mfbc_fields_s;

    // register type targeted by an operand reference
    typedef enum logic [2:0] {
        MFBC_TGT_ADDR,
        MFBC_TGT_IADDR,
        MFBC_TGT_SCALAR,
        MFBC_TGT_ISCALAR,
        MFBC_TGT_VECTOR,
        MFBC_TGT_OTHER
    } mfbc_target_e;

    // ------------------------------------------------------------
    // shared arithmetic
    // ------------------------------------------------------------
    // expand a stored field to a 24-bit address
    function automatic mfbc_addr_t field_to_addr(input mfbc_field_t f);
        return {f, ALIGN_ZERO};
    endfunction

    // relocate and wrap modulo 2^24
    function automatic mfbc_addr_t relocate(input mfbc_field_t base,
                                            input mfbc_addr_t  rel);
        return mfbc_addr_t'(field_to_addr(base) + rel);
    endfunction

endpackage

// File: hdl/mfbc_range_check.sv
/*
 * one relocation and bounds check: base plus relative address, then an
 * unsigned compare against base and limit. purely combinational.
 * assumes base and limit are held stable by the caller.
 */
`timescale 1ns/1ps
`default_nettype none

module mfbc_range_check
    import mfbc_pkg::*;
(
    input  wire logic [FIELD_W-1:0] base,
    input  wire logic [FIELD_W-1:0] limit,
    input  wire logic [ADDR_W-1:0]  rel_addr,
    output logic      [ADDR_W-1:0]  abs_addr,
    output logic                    in_range
);

    // ------------------------------------------------------------
    // relocation and compare
    // ------------------------------------------------------------
    // compare runs on the wrapped sum, so a jump past memory size
    // lands below base and is caught there
    always_comb begin
        abs_addr = relocate(base, rel_addr);
        in_range = (abs_addr >= field_to_addr(base)) &&
                   (abs_addr <  field_to_addr(limit));
    end

endmodule

`default_nettype wire

// File: hdl/mfbc_top.sv
/*
 * memory field bounds checker: relocates instruction fetches and operand
 * references, forwards them to central memory, zeroes out-of-field read
 * data, suppresses out-of-field writes and raises sticky range flags.
 * assumes the processor loads the field registers during an exchange and
 * clears the flags once the monitor has consumed them; memory answers
 * every request issued without the write strobe with one read-valid
 * pulse, in order.
 */
`timescale 1ns/1ps
`default_nettype none

module mfbc_top
    import mfbc_pkg::*;
(
    input  wire logic                CLK,
    input  wire logic                RESET,
    // field register load from the exchange sequence
    input  wire logic                FIELD_LOAD,
    input  wire mfbc_fields_s        FIELD_IN,
    output mfbc_fields_s             FIELD_OUT,
    // mode and flag control
    input  wire logic                OPERAND_RANGE_MODE,
    input  wire logic                FLAG_CLEAR,
    // instruction buffer fetch
    input  wire logic                IFETCH_REQ,
    input  wire logic [PC_W-1:0]     IFETCH_PC,
    // operand fetch or store
    input  wire logic                OPND_REQ,
    input  wire logic                OPND_WRITE,
    input  wire logic [ADDR_W-1:0]   OPND_ADDR,
    input  wire logic [DATA_W-1:0]   OPND_WDATA,
    input  wire mfbc_target_e        OPND_TARGET,
    // central memory side
    output logic                     MEM_REQ,
    output logic                     MEM_WRITE,
    output logic [ADDR_W-1:0]        MEM_ADDR,
    output logic [DATA_W-1:0]        MEM_WDATA,
    input  wire logic                MEM_RVALID,
    input  wire logic [DATA_W-1:0]   MEM_RDATA,
    // read return to the processor
    output logic                     RD_VALID,
    output logic [DATA_W-1:0]        RD_DATA,
    // flags and interrupt request
    output logic                     PROGRAM_RANGE_ERR,
    output logic                     OPERAND_RANGE_ERR,
    output logic                     REQUEST_INTERRUPT,
    output logic                     TERMINATE_PROGRAM
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    localparam int PEND_DEPTH = 16;   // outstanding reads tracked
    localparam int PEND_AW    = 4;

    mfbc_fields_s      fields_r, fields_nxt;
    logic [ADDR_W-1:0] i_abs, d_abs;
    logic              i_ok, d_ok;
    logic [ADDR_W-1:0] pc_word;

    logic              mem_req_r, mem_req_nxt;
    logic              mem_write_r, mem_write_nxt;
    logic [ADDR_W-1:0] mem_addr_r, mem_addr_nxt;
    logic [DATA_W-1:0] mem_wdata_r, mem_wdata_nxt;

    logic              prog_err_r, prog_err_nxt;
    logic              opnd_err_r, opnd_err_nxt;

    logic              rd_valid_r, rd_valid_nxt;
    logic [DATA_W-1:0] rd_data_r, rd_data_nxt;

    // per read: was it out of field, so its data must be zeroed
    logic [PEND_DEPTH-1:0] bad_q_r, bad_q_nxt;
    // per entry: a suppressed store, whose return is swallowed
    logic [PEND_DEPTH-1:0] drop_q_r, drop_q_nxt;
    logic [PEND_AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;

    logic              fetch_go, opnd_go, opnd_bad, fetch_bad;
    logic              opnd_tgt_reg;

    // ------------------------------------------------------------
    // relocation units
    // ------------------------------------------------------------
    // program counter holds the high-order bits of the word address
    assign pc_word = {IFETCH_PC, 2'h0};

    mfbc_range_check u_ichk (
        .base     (fields_r.instruction_field_base),
        .limit    (fields_r.instruction_field_limit),
        .rel_addr (pc_word),
        .abs_addr (i_abs),
        .in_range (i_ok)
    );

    mfbc_range_check u_dchk (
        .base     (fields_r.data_field_base),
        .limit    (fields_r.data_field_limit),
        .rel_addr (OPND_ADDR),
        .abs_addr (d_abs),
        .in_range (d_ok)
    );

    // ------------------------------------------------------------
    // field registers
    // ------------------------------------------------------------
    // loaded whole by the exchange, so checks never see a mixed context
    always_comb begin
        fields_nxt = fields_r;
        if (FIELD_LOAD) begin
            fields_nxt = FIELD_IN;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            fields_r <= '0;
        end else begin
            fields_r <= fields_nxt;
        end
    end

    assign FIELD_OUT = fields_r;

    // ------------------------------------------------------------
    // request arbitration and memory issue
    // ------------------------------------------------------------
    // operands win over instruction fetch when both arrive; the fetch
    // side is expected to retry, which keeps the path a single port
    always_comb begin
        opnd_go   = OPND_REQ;
        fetch_go  = IFETCH_REQ && !OPND_REQ;
        opnd_bad  = opnd_go && !d_ok;
        fetch_bad = fetch_go && !i_ok;

        mem_req_nxt   = opnd_go || fetch_go;
        mem_write_nxt = 1'b0;
        mem_addr_nxt  = mem_addr_r;
        mem_wdata_nxt = mem_wdata_r;
        if (opnd_go) begin
            mem_addr_nxt  = d_abs;
            // write still issues, but the strobe is dropped
            mem_write_nxt = OPND_WRITE && d_ok;
            mem_wdata_nxt = OPND_WDATA;
        end else if (fetch_go) begin
            mem_addr_nxt  = i_abs;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            mem_req_r   <= 1'b0;
            mem_write_r <= 1'b0;
            mem_addr_r  <= '0;
            mem_wdata_r <= '0;
        end else begin
            mem_req_r   <= mem_req_nxt;
            mem_write_r <= mem_write_nxt;
            mem_addr_r  <= mem_addr_nxt;
            mem_wdata_r <= mem_wdata_nxt;
        end
    end

    assign MEM_REQ   = mem_req_r;
    assign MEM_WRITE = mem_write_r;
    assign MEM_ADDR  = mem_addr_r;
    assign MEM_WDATA = mem_wdata_r;

    // ------------------------------------------------------------
    // outstanding read tracking and zero substitution
    // ------------------------------------------------------------
    // a small ring of bad-bits keeps returned data paired with its
    // request; more than PEND_DEPTH reads in flight would alias.
    // a suppressed store looks like a load to memory, so it takes a
    // slot too and its return never reaches the processor
    always_comb begin
        bad_q_nxt    = bad_q_r;
        drop_q_nxt   = drop_q_r;
        wp_nxt       = wp_r;
        rp_nxt       = rp_r;
        rd_valid_nxt = 1'b0;
        rd_data_nxt  = rd_data_r;
        if (mem_req_nxt && !mem_write_nxt) begin
            bad_q_nxt[wp_r]  = opnd_bad || fetch_bad;
            drop_q_nxt[wp_r] = opnd_go && OPND_WRITE;
            wp_nxt           = wp_r + 1'b1;
        end
        if (MEM_RVALID) begin
            rd_valid_nxt = !drop_q_r[rp_r];
            rd_data_nxt  = bad_q_r[rp_r] ? '0 : MEM_RDATA;
            rp_nxt       = rp_r + 1'b1;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            bad_q_r    <= '0;
            drop_q_r   <= '0;
            wp_r       <= '0;
            rp_r       <= '0;
            rd_valid_r <= 1'b0;
            rd_data_r  <= '0;
        end else begin
            bad_q_r    <= bad_q_nxt;
            drop_q_r   <= drop_q_nxt;
            wp_r       <= wp_nxt;
            rp_r       <= rp_nxt;
            rd_valid_r <= rd_valid_nxt;
            rd_data_r  <= rd_data_nxt;
        end
    end

    assign RD_VALID = rd_valid_r;
    assign RD_DATA  = rd_data_r;

    // ------------------------------------------------------------
    // range error flags
    // ------------------------------------------------------------
    // only the five register classes are watched for operand errors
    always_comb begin
        unique case (OPND_TARGET)
            MFBC_TGT_ADDR, MFBC_TGT_IADDR, MFBC_TGT_SCALAR,
            MFBC_TGT_ISCALAR, MFBC_TGT_VECTOR: opnd_tgt_reg = 1'b1;
            default:                           opnd_tgt_reg = 1'b0;
        endcase
    end

    // sticky; a new error in the clearing cycle wins over the clear
    always_comb begin
        prog_err_nxt = prog_err_r && !FLAG_CLEAR;
        opnd_err_nxt = opnd_err_r && !FLAG_CLEAR;
        if (fetch_bad) begin
            prog_err_nxt = 1'b1;
        end
        if (opnd_bad && OPERAND_RANGE_MODE && opnd_tgt_reg) begin
            opnd_err_nxt = 1'b1;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            prog_err_r <= 1'b0;
            opnd_err_r <= 1'b0;
        end else begin
            prog_err_r <= prog_err_nxt;
            opnd_err_r <= opnd_err_nxt;
        end
    end

    // ------------------------------------------------------------
    // interrupt request and termination
    // ------------------------------------------------------------
    assign PROGRAM_RANGE_ERR = prog_err_r;
    assign OPERAND_RANGE_ERR = opnd_err_r;
    assign REQUEST_INTERRUPT = prog_err_r || opnd_err_r;
    assign TERMINATE_PROGRAM = prog_err_r || opnd_err_r;

endmodule

`default_nettype wire

// File: test/mfbc_monitor.sv
/* checker for mfbc_top: relocation, write gating and range flags.
   assumes it is bound to every mfbc_top and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module mfbc_monitor
    import mfbc_pkg::*;
(
    input wire logic              CLK,
    input wire logic              RESET,
    input wire mfbc_fields_s      FIELD_OUT,
    input wire logic              OPERAND_RANGE_MODE,
    input wire logic              FLAG_CLEAR,
    input wire logic              IFETCH_REQ,
    input wire logic [PC_W-1:0]   IFETCH_PC,
    input wire logic              OPND_REQ,
    input wire logic              OPND_WRITE,
    input wire logic [ADDR_W-1:0] OPND_ADDR,
    input wire mfbc_target_e      OPND_TARGET,
    input wire logic              MEM_REQ,
    input wire logic              MEM_WRITE,
    input wire logic [ADDR_W-1:0] MEM_ADDR,
    input wire logic              MEM_RVALID,
    input wire logic              RD_VALID,
    input wire logic              PROGRAM_RANGE_ERR,
    input wire logic              OPERAND_RANGE_ERR,
    input wire logic              REQUEST_INTERRUPT,
    input wire logic              TERMINATE_PROGRAM
);
    // ------------------------------------------------------------
    // relocated addresses; compares on the wrapped value, so a
    // negative offset lands below base and is caught there
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] o_abs, f_abs, db, dl, ib, il;
    logic              o_err, f_err, o_in, f_in;
    assign db = {FIELD_OUT.data_field_base, 6'h00};
    assign dl = {FIELD_OUT.data_field_limit, 6'h00};
    assign ib = {FIELD_OUT.instruction_field_base, 6'h00};
    assign il = {FIELD_OUT.instruction_field_limit, 6'h00};
    assign o_abs = db + OPND_ADDR;
    assign f_abs = ib + {IFETCH_PC, 2'h0};
    assign o_in = o_abs >= db && o_abs < dl;
    assign f_in = f_abs >= ib && f_abs < il;
    assign o_err = OPND_REQ && !o_in && OPERAND_RANGE_MODE && OPND_TARGET <= MFBC_TGT_VECTOR;
    assign f_err = IFETCH_REQ && !OPND_REQ && !f_in;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    sequence issued(logic [ADDR_W-1:0] x);
        MEM_REQ && MEM_ADDR == x;
    endsequence
    opnd_reloc_a: assert property (OPND_REQ |=> issued($past(o_abs)))
        else $error("operand address not relocated");
    fetch_reloc_a: assert property (IFETCH_REQ && !OPND_REQ |=> issued($past(f_abs)))
        else $error("fetch address not relocated");
    write_gate_a: assert property (OPND_REQ && OPND_WRITE |=> MEM_WRITE == $past(o_in))
        else $error("store gating wrong");
    prog_flag_a: assert property (f_err |=> PROGRAM_RANGE_ERR && REQUEST_INTERRUPT)
        else $error("program range flag missing");
    opnd_flag_a: assert property (o_err |=> OPERAND_RANGE_ERR && REQUEST_INTERRUPT)
        else $error("operand range flag missing");
    opnd_quiet_a: assert property ($rose(OPERAND_RANGE_ERR) |-> $past(o_err))
        else $error("operand range flag without cause");
    prog_quiet_a: assert property ($rose(PROGRAM_RANGE_ERR) |-> $past(f_err))
        else $error("program range flag without cause");
    flag_hold_a: assert property (OPERAND_RANGE_ERR && !FLAG_CLEAR |=> OPERAND_RANGE_ERR)
        else $error("operand range flag dropped");
    exit_req_a: assert property (TERMINATE_PROGRAM == REQUEST_INTERRUPT
        && REQUEST_INTERRUPT == (PROGRAM_RANGE_ERR || OPERAND_RANGE_ERR))
        else $error("interrupt request not the flag or");
    rd_return_a: assert property (RD_VALID |-> $past(MEM_RVALID))
        else $error("read return without memory answer");
    set_wins_a: assert property (FLAG_CLEAR && o_err |=> OPERAND_RANGE_ERR)
        else $error("operand error lost to flag clear");
    flag_clear_a: assert property (FLAG_CLEAR && !o_err && !f_err |=> !REQUEST_INTERRUPT)
        else $error("flags not cleared");
endmodule
bind mfbc_top mfbc_monitor u_monitor (.CLK, .RESET, .FIELD_OUT, .OPERAND_RANGE_MODE,
    .FLAG_CLEAR, .IFETCH_REQ, .IFETCH_PC, .OPND_REQ, .OPND_WRITE, .OPND_ADDR, .OPND_TARGET,
    .MEM_REQ, .MEM_WRITE, .MEM_ADDR, .MEM_RVALID, .RD_VALID, .PROGRAM_RANGE_ERR,
    .OPERAND_RANGE_ERR, .REQUEST_INTERRUPT, .TERMINATE_PROGRAM);
`default_nettype wire

// File: test/mfbc_mem_model.sv
/* behavioural central memory: in-order read returns after a variable wait.
   assumes requests are single-cycle pulses; unwritten words read their address. */
`timescale 1ns/1ps
`default_nettype none
module mfbc_mem_model
    import mfbc_pkg::*;
(
    input wire logic              CLK,
    input wire logic [3:0]        delay,
    input wire logic              MEM_REQ,
    input wire logic              MEM_WRITE,
    input wire logic [ADDR_W-1:0] MEM_ADDR,
    input wire logic [DATA_W-1:0] MEM_WDATA,
    output logic                  MEM_RVALID,
    output logic [DATA_W-1:0]     MEM_RDATA
);
    logic [DATA_W-1:0] mem[logic [ADDR_W-1:0]];
    logic [DATA_W-1:0] q[$];
    int                wait_n = 0;
    initial MEM_RVALID = 1'h0;
    initial MEM_RDATA = 64'h0;
    // data lines toggle when idle so stale data never looks valid
    always @(posedge CLK) begin
        if (MEM_REQ && MEM_WRITE) mem[MEM_ADDR] = MEM_WDATA;
        else if (MEM_REQ) q.push_back(mem.exists(MEM_ADDR) ? mem[MEM_ADDR] : {40'h0, MEM_ADDR});
        if (wait_n == 0 && q.size() != 0) begin
            MEM_RVALID <= 1'h1;
            MEM_RDATA <= q.pop_front();
            wait_n = delay;
        end else begin
            if (wait_n != 0) wait_n--;
            MEM_RVALID <= 1'h0;
            MEM_RDATA <= ~MEM_RDATA;
        end
    end
endmodule
`default_nettype wire

// File: test/testbench.sv
/* self-checking bench for mfbc_top with the behavioural memory.
   assumes the monitor is bound and the package is compiled first. */
`timescale 1ns/1ps
`default_nettype none
module testbench
    import mfbc_pkg::*;
;
    logic CLK = 1'h0, RESET = 1'h1, FIELD_LOAD = 1'h0, OPERAND_RANGE_MODE = 1'h0;
    logic FLAG_CLEAR = 1'h0, IFETCH_REQ = 1'h0, OPND_REQ = 1'h0, OPND_WRITE = 1'h0;
    logic MEM_RVALID, MEM_REQ, MEM_WRITE, RD_VALID, inr;
    logic PROGRAM_RANGE_ERR, OPERAND_RANGE_ERR, REQUEST_INTERRUPT, TERMINATE_PROGRAM;
    mfbc_fields_s FIELD_IN = '0, FIELD_OUT;
    mfbc_target_e OPND_TARGET = MFBC_TGT_ADDR;
    logic [PC_W-1:0] IFETCH_PC = '0;
    logic [ADDR_W-1:0] OPND_ADDR = '0, MEM_ADDR, a;
    logic [DATA_W-1:0] OPND_WDATA = '0, MEM_WDATA, MEM_RDATA, RD_DATA, wd;
    logic [DATA_W-1:0] exp_q[$], wmem[logic [ADDR_W-1:0]];
    logic [FIELD_W-1:0] ib, il, db, dl;
    logic [3:0] mem_delay = 4'h0;
    logic [31:0] seed = 32'hf0efa7d8;
    int errors = 0, samples_checked = 0, cycles = 0;
    mfbc_top dut (.CLK, .RESET, .FIELD_LOAD, .FIELD_IN, .FIELD_OUT, .OPERAND_RANGE_MODE,
        .FLAG_CLEAR, .IFETCH_REQ, .IFETCH_PC, .OPND_REQ, .OPND_WRITE, .OPND_ADDR,
        .OPND_WDATA, .OPND_TARGET, .MEM_REQ, .MEM_WRITE, .MEM_ADDR, .MEM_WDATA, .MEM_RVALID,
        .MEM_RDATA, .RD_VALID, .RD_DATA, .PROGRAM_RANGE_ERR, .OPERAND_RANGE_ERR,
        .REQUEST_INTERRUPT, .TERMINATE_PROGRAM);
    mfbc_mem_model mem (.CLK, .delay(mem_delay), .MEM_REQ, .MEM_WRITE, .MEM_ADDR,
        .MEM_WDATA, .MEM_RVALID, .MEM_RDATA);
    // ------------------------------------------------------------
    // clock, timeout and helpers
    // ------------------------------------------------------------
    always #5 CLK = ~CLK;
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            finish_test();
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // strobes stay up until idle, so back-to-back calls issue one request per cycle
    task automatic opnd(input logic wr, input logic [ADDR_W-1:0] rel,
                        input mfbc_target_e t, input logic m);
        @(posedge CLK);
        wd = {rnd(), rnd()};
        {OPND_REQ, OPND_WRITE, OPND_ADDR, OPND_WDATA} <= {1'h1, wr, rel, wd};
        OPND_TARGET <= t;
        OPERAND_RANGE_MODE <= m;
        mem_delay <= 4'(rnd() & 32'h3);
        a = {db, 6'h00} + rel;
        inr = a >= {db, 6'h00} && a < {dl, 6'h00};
        if (wr && inr) wmem[a] = wd;
        if (!wr) exp_q.push_back(!inr ? 64'h0 : wmem.exists(a) ? wmem[a] : {40'h0, a});
    endtask
    task automatic fetch(input logic [PC_W-1:0] pc);
        @(posedge CLK);
        {IFETCH_REQ, IFETCH_PC} <= {1'h1, pc};
        a = {ib, 6'h00} + {pc, 2'h0};
        exp_q.push_back(a >= {ib, 6'h00} && a < {il, 6'h00} ? {40'h0, a} : 64'h0);
    endtask
    task automatic idle();
        @(posedge CLK);
        {OPND_REQ, IFETCH_REQ, FLAG_CLEAR, FIELD_LOAD} <= 4'h0;
        #1;
    endtask
    task automatic clear();
        @(posedge CLK);
        FLAG_CLEAR <= 1'h1;
        idle();
        chk(REQUEST_INTERRUPT, 1'h0);
    endtask
    task automatic drain();
        for (int i = 0; i < 40 && exp_q.size() != 0; i++) @(posedge CLK);
        chk(exp_q.size(), 0);
    endtask
    // read returns are paired in order with the oldest expectation
    always @(negedge CLK) begin
        // an unexpected return is compared against a value it can never match
        if (RD_VALID === 1'h1) chk(RD_DATA, exp_q.size() ? exp_q.pop_front() : {16'h1, 64'h0});
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge CLK);
        RESET <= 1'h0;
        #1;
        chk({FIELD_OUT, REQUEST_INTERRUPT}, 73'h0);
        ib = 18'h00400 + 18'(rnd() & 32'hff);
        il = ib + 18'h2;
        db = 18'h01000 + 18'(rnd() & 32'hff);
        dl = db + 18'h1;
        @(posedge CLK);
        {FIELD_LOAD, FIELD_IN} <= {1'h1, ib, il, db, dl};
        idle();
        chk(FIELD_OUT, {ib, il, db, dl});
        $display("test reset and load done");
        for (int m = 0; m < 2; m++) begin
            for (int t = 0; t < 6; t++) begin
                opnd(1'h0, 24'h40, mfbc_target_e'(t), m[0]);
                idle();
                chk(MEM_ADDR, {db, 6'h00} + 24'h40);
                chk(OPERAND_RANGE_ERR, m == 1 && t < 5);
                chk(TERMINATE_PROGRAM, m == 1 && t < 5);
                clear();
            end
        end
        $display("test target codes done");
        opnd(1'h0, 24'h0, MFBC_TGT_SCALAR, 1'h1);
        opnd(1'h0, 24'h3f, MFBC_TGT_SCALAR, 1'h1);
        opnd(1'h0, 24'hffffff, MFBC_TGT_SCALAR, 1'h1);
        idle();
        chk(OPERAND_RANGE_ERR, 1'h1);
        clear();
        drain();
        $display("test operand bounds done");
        for (int i = 0; i < 4; i++) begin
            fetch(i == 0 ? 22'h0 : i == 3 ? 22'h3fffff : 22'(32'(il - ib) * 16 - 2 + i));
            idle();
            chk(MEM_ADDR, a);
            chk(PROGRAM_RANGE_ERR, i > 1);
            clear();
        end
        opnd(1'h0, 24'h1, MFBC_TGT_ADDR, 1'h1);
        {IFETCH_REQ, IFETCH_PC} <= {1'h1, 22'h3fffff};
        idle();
        chk({MEM_ADDR, PROGRAM_RANGE_ERR}, {a, 1'h0});
        drain();
        $display("test fetch bounds done");
        opnd(1'h1, 24'h5, MFBC_TGT_SCALAR, 1'h1);
        idle();
        chk({MEM_WRITE, MEM_WDATA}, {1'h1, wd});
        opnd(1'h0, 24'h5, MFBC_TGT_ISCALAR, 1'h1);
        idle();
        drain();
        opnd(1'h1, 24'h40, MFBC_TGT_VECTOR, 1'h1);
        idle();
        chk({MEM_WRITE, OPERAND_RANGE_ERR}, 2'h1);
        // a new error in the clearing cycle must win over the clear
        opnd(1'h1, 24'h40, MFBC_TGT_VECTOR, 1'h1);
        FLAG_CLEAR <= 1'h1;
        idle();
        chk(OPERAND_RANGE_ERR, 1'h1);
        clear();
        repeat (8) @(posedge CLK);
        chk(exp_q.size(), 0);
        $display("test stores done");
        finish_test();
    end
endmodule
`default_nettype wire
